// *** include/snand_pkg.sv ***
/*
 * shared constants and types of the serial nand front end: address field
 * layout, page geometry, command codes and the decoded-command carrier.
 * assumes a single core clock domain; the serial clock is only sampled.
 */
package snand_pkg;

	localparam int BLOCK_W = 10;
	localparam int PAGE_W = 6;
	localparam int ROW_W = 16;
	localparam int COL_W = 12;
	localparam int BLOCK_COUNT = 1024;
	localparam int PAGES_PER_BLOCK = 64;
	localparam int MAIN_BYTES = 2048;
	localparam int SPARE_ECC_ON = 64;
	localparam int SPARE_ECC_OFF = 128;
	localparam logic [COL_W-1:0] PAGE_LEN_ECC_ON = COL_W'(MAIN_BYTES + SPARE_ECC_ON);
	localparam logic [COL_W-1:0] PAGE_LEN_ECC_OFF = COL_W'(MAIN_BYTES + SPARE_ECC_OFF);
	localparam logic [BLOCK_W-1:0] GOOD_BLOCK = 10'h000;

	localparam int SYNC_W = 4;
	localparam int SYNC_SCK = 0;
	localparam int SYNC_CS_N = 1;
	localparam int SYNC_SI = 2;
	localparam int SYNC_HOLD_N = 3;

	localparam logic [1:0] ROW_HDR_BYTES = 2'h3;
	localparam logic [1:0] COL_HDR_BYTES = 2'h2;
	localparam logic [1:0] RDBUF_HDR_BYTES = 2'h3;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;

	localparam logic [7:0] OP_ERASE = 8'hD8;
	localparam logic [7:0] OP_READ_CELL = 8'h13;
	localparam logic [7:0] OP_PROG_EXEC = 8'h10;
	localparam logic [7:0] OP_READ_BUF = 8'h03;
	localparam logic [7:0] OP_PROG_LOAD = 8'h02;

	typedef enum logic [4:0] {
		ST_CMD = 5'b00001,
		ST_ADDR = 5'b00010,
		ST_DATA_IN = 5'b00100,
		ST_DATA_OUT = 5'b01000,
		ST_IGNORE = 5'b10000
	} link_state_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic has_row;
		logic has_col;
		logic [BLOCK_W-1:0] block;
		logic [PAGE_W-1:0] page;
		logic [COL_W-1:0] column_addr;
		logic col_in_spare;
		logic col_range_err;
		logic block_guaranteed;
	} cmd_t;

endpackage

// *** verilog/snand_fifo.sv ***
/*
 * small flip-flop fifo with valid/ready on both sides.
 * assumes both sides run on the same clock; depth is a power of two.
 */
`timescale 1ns/1ns
module snand_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready_o = (count != (AW+1)'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			case ({push, pop})
				2'b10: count <= count + (AW+1)'(1);
				2'b01: count <= count - (AW+1)'(1);
				default: count <= count;
			endcase
		end
	end
endmodule // snand_fifo

// *** verilog/serial_nand_spi_addressing.sv ***
/*
 * serial front end of a nand device: samples the host serial link on the
 * core clock, decodes command and row/column address bytes, passes program
 * data out and feeds read data back through a small fifo.
 * assumes the serial clock is well below half the core clock and that the
 * array side keeps the read fifo topped up while a read streams.
 */
`timescale 1ns/1ns
module serial_nand_spi_addressing #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	input wire logic hold_n_i,
	output logic so_o,
	output logic so_oe_n_o,
	input wire logic ecc_en_i,
	output snand_pkg::cmd_t cmd_o,
	output logic cmd_valid_o,
	output logic [7:0] wr_data_o,
	output logic wr_valid_o,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i,
	output logic rd_ready_o,
	output logic held_o
);
	import snand_pkg::*;

	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	logic sck_prev;
	logic sck_s;
	logic cs_act;
	logic si_s;
	logic hold_s;
	logic sck_rise;
	logic sck_fall;
	logic held;
	logic rise_ok;
	logic fall_ok;
	link_state_t state;
	logic [2:0] rx_bit;
	logic [6:0] rx_sh;
	logic [7:0] rx_byte;
	logic byte_done;
	logic [7:0] opcode;
	logic [1:0] hdr_left;
	logic [23:0] addr_sh;
	logic [23:0] next_addr;
	logic [2:0] tx_bit;
	logic [6:0] tx_sh;
	logic fifo_pop;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic [ROW_W-1:0] row_addr;
	logic [COL_W-1:0] column_addr;
	logic [COL_W-1:0] page_len;

	// two flops on every pin before any logic looks at it
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sync1 <= 4'hA;
			sync2 <= 4'hA;
			sck_prev <= 1'b0;
		end else begin
			sync1 <= {hold_n_i, si_i, cs_n_i, sck_i};
			sync2 <= sync1;
			sck_prev <= sync2[SYNC_SCK];
		end
	end

	assign sck_s = sync2[SYNC_SCK];
	assign cs_act = ~sync2[SYNC_CS_N];
	assign si_s = sync2[SYNC_SI];
	assign hold_s = sync2[SYNC_HOLD_N];
	// idle level of the clock is never decoded, so mode 0 and mode 3 both work
	assign sck_rise = cs_act & sck_s & ~sck_prev;
	assign sck_fall = cs_act & ~sck_s & sck_prev;
	// a falling edge seen with hold low enters hold instead of shifting
	assign rise_ok = sck_rise & ~held;
	assign fall_ok = sck_fall & ~held & hold_s;
	assign byte_done = rise_ok & (rx_bit == 3'h7);
	assign rx_byte = {rx_sh, si_s};
	assign held_o = held;

	// hold starts only on a falling edge, ends as soon as the pin returns high
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			held <= 1'b0;
		end else if (!cs_act || hold_s) begin
			held <= 1'b0;
		end else if (sck_fall) begin
			held <= 1'b1;
		end
	end

	// bit counters are frozen while held so nothing is lost or repeated
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rx_bit <= 3'h0;
			rx_sh <= 7'h00;
		end else if (!cs_act) begin
			rx_bit <= 3'h0;
		end else if (rise_ok) begin
			rx_sh <= rx_byte[6:0];
			rx_bit <= rx_bit + 3'h1;
		end
	end

	// address bytes arrive msb first; the newest byte is the low byte
	assign next_addr = {addr_sh[15:0], rx_byte};

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state <= ST_CMD;
			opcode <= 8'h00;
			hdr_left <= 2'h0;
			addr_sh <= 24'h000000;
		end else if (!cs_act) begin
			state <= ST_CMD;
		end else if (byte_done) begin
			case (state)
				ST_CMD: begin
					opcode <= rx_byte;
					addr_sh <= 24'h000000;
					if (rx_byte == OP_ERASE || rx_byte == OP_READ_CELL ||
						rx_byte == OP_PROG_EXEC) begin
						hdr_left <= ROW_HDR_BYTES;
						state <= ST_ADDR;
					end else if (rx_byte == OP_PROG_LOAD) begin
						hdr_left <= COL_HDR_BYTES;
						state <= ST_ADDR;
					end else if (rx_byte == OP_READ_BUF) begin
						// two column bytes then one dummy byte
						hdr_left <= RDBUF_HDR_BYTES;
						state <= ST_ADDR;
					end else begin
						state <= ST_IGNORE;
					end
				end
				ST_ADDR: begin
					hdr_left <= hdr_left - 2'h1;
					if (!(opcode == OP_READ_BUF && hdr_left == 2'h1)) begin
						addr_sh <= next_addr;
					end
					if (hdr_left == 2'h1) begin
						if (opcode == OP_PROG_LOAD) begin
							state <= ST_DATA_IN;
						end else if (opcode == OP_READ_BUF) begin
							state <= ST_DATA_OUT;
						end else begin
							state <= ST_IGNORE;
						end
					end
				end
				ST_DATA_IN: state <= ST_DATA_IN;
				ST_DATA_OUT: state <= ST_DATA_OUT;
				ST_IGNORE: state <= ST_IGNORE;
				default: state <= ST_CMD;
			endcase
		end
	end

	// row and column views of the completed header
	assign row_addr = (opcode == OP_READ_BUF) ? addr_sh[ROW_W-1:0] : next_addr[ROW_W-1:0];
	assign column_addr = (opcode == OP_READ_BUF) ? addr_sh[COL_W-1:0] :
		next_addr[COL_W-1:0];
	assign page_len = ecc_en_i ? PAGE_LEN_ECC_ON : PAGE_LEN_ECC_OFF;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cmd_o <= '0;
			cmd_valid_o <= 1'b0;
		end else begin
			cmd_valid_o <= 1'b0;
			if (byte_done && state == ST_ADDR && hdr_left == 2'h1) begin
				cmd_valid_o <= 1'b1;
				cmd_o.opcode <= opcode;
				if (opcode == OP_PROG_LOAD || opcode == OP_READ_BUF) begin
					cmd_o.has_row <= 1'b0;
					cmd_o.has_col <= 1'b1;
					cmd_o.block <= '0;
					cmd_o.page <= '0;
					cmd_o.column_addr <= column_addr;
					cmd_o.col_in_spare <= column_addr >= COL_W'(MAIN_BYTES);
					cmd_o.col_range_err <= column_addr >= page_len;
					cmd_o.block_guaranteed <= 1'b0;
				end else begin
					cmd_o.has_row <= 1'b1;
					cmd_o.has_col <= 1'b0;
					cmd_o.block <= row_addr[ROW_W-1:PAGE_W];
					cmd_o.page <= row_addr[PAGE_W-1:0];
					cmd_o.column_addr <= '0;
					cmd_o.col_in_spare <= 1'b0;
					cmd_o.col_range_err <= 1'b0;
					cmd_o.block_guaranteed <= row_addr[ROW_W-1:PAGE_W] == GOOD_BLOCK;
				end
			end
		end
	end

	// program data leaves as whole bytes; the array side cannot stall the link
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			wr_data_o <= 8'h00;
			wr_valid_o <= 1'b0;
		end else begin
			wr_valid_o <= byte_done && state == ST_DATA_IN;
			if (byte_done && state == ST_DATA_IN) begin
				wr_data_o <= rx_byte;
			end
		end
	end

	// read data is pulled one byte at a time at the first falling edge of a byte
	assign fifo_pop = fall_ok && state == ST_DATA_OUT && tx_bit == 3'h0;

	snand_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_rd_fifo (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(rd_valid_i),
		.in_ready_o(rd_ready_o),
		.in_data_i(rd_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_data)
	);

	// output bits move only on falling edges; an empty fifo sends idle ones
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			tx_bit <= 3'h0;
			tx_sh <= 7'h7F;
			so_o <= 1'b1;
		end else if (!cs_act) begin
			tx_bit <= 3'h0;
		end else if (fall_ok && state == ST_DATA_OUT) begin
			tx_bit <= tx_bit + 3'h1;
			if (tx_bit == 3'h0) begin
				so_o <= fifo_valid ? fifo_data[7] : IDLE_BYTE[7];
				tx_sh <= fifo_valid ? fifo_data[6:0] : IDLE_BYTE[6:0];
			end else begin
				so_o <= tx_sh[6];
				tx_sh <= {tx_sh[5:0], 1'b0};
			end
		end
	end

	// output released while deselected or held
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			so_oe_n_o <= 1'b1;
		end else begin
			so_oe_n_o <= !(cs_act && state == ST_DATA_OUT && !held);
		end
	end
endmodule // serial_nand_spi_addressing

// *** verification/serial_nand_spi_addressing_properties.sv ***
/* port checker of the serial nand front end.
   assumes serial half periods of 4 core cycles, as the bench makes. */
`timescale 1ns/1ns
module snand_checker #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	input wire logic hold_n_i,
	input wire logic so_o,
	input wire logic so_oe_n_o,
	input wire logic ecc_en_i,
	input wire snand_pkg::cmd_t cmd_o,
	input wire logic cmd_valid_o,
	input wire logic [7:0] wr_data_o,
	input wire logic wr_valid_o,
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i,
	input wire logic rd_ready_o,
	input wire logic held_o
);
	import snand_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	oe_deselect_a: assert property (cs_n_i [*4] |-> so_oe_n_o)
		else $error("so driven while deselected");
	oe_held_a: assert property (held_o && $past(held_o) |-> so_oe_n_o)
		else $error("so driven while held");
	so_frozen_a: assert property (held_o && $past(held_o) |-> $stable(so_o))
		else $error("so moved while held");
	hold_entry_a: assert property ($rose(held_o) |-> !$past(sck_i) && $past(sck_i, 4))
		else $error("hold began off a falling edge");
	hold_exit_a: assert property (hold_n_i [*4] |-> !held_o)
		else $error("hold kept after release");
	so_edge_a: assert property ($changed(so_o) && !so_oe_n_o |-> !$past(sck_i) && $past(sck_i, 4))
		else $error("so changed off a falling edge");
	row_only_a: assert property (cmd_valid_o && cmd_o.has_row |-> !cmd_o.has_col &&
		cmd_o.column_addr == 12'h000 && cmd_o.block_guaranteed == (cmd_o.block == 10'h000))
		else $error("row command fields wrong");
	col_range_a: assert property (cmd_valid_o && cmd_o.has_col |->
		cmd_o.col_range_err == (cmd_o.column_addr >= (ecc_en_i ? 12'h840 : 12'h880)) &&
		cmd_o.col_in_spare == (cmd_o.column_addr >= 12'h800))
		else $error("column flags wrong");
endmodule // snand_checker

bind serial_nand_spi_addressing snand_checker #(.FIFO_DEPTH(FIFO_DEPTH)) snand_checker_i (
	.core_clk_i, .rst_n_i, .sck_i, .cs_n_i, .si_i, .hold_n_i, .so_o, .so_oe_n_o, .ecc_en_i,
	.cmd_o, .cmd_valid_o, .wr_data_o, .wr_valid_o, .rd_data_i, .rd_valid_i, .rd_ready_o, .held_o);

// *** verification/snand_host.sv ***
/* host serial controller model, 800 ns serial clock.
   assumes its tasks are called one at a time by the bench. */
`timescale 1ns/1ns
module snand_host (
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o,
	output logic hold_n_o,
	input wire logic so_i
);
	int mode = 0;
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
		hold_n_o = 1'b1;
	end
	// idle clock level follows the mode, 0 or 3 only
	// idle level settles well before select, else the core sees a false edge in the frame
	task start(input int m);
		mode = m;
		sck_o = (m == 3);
		#413 cs_n_o = 1'b0;
		#400;
	endtask
	// msb first, 1.25 MHz, far under the ceiling
	task xfer(input logic [7:0] tx, input int hold_bit, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			if (i == hold_bit) begin
				hold_n_o = 1'b0;
				#400 sck_o = 1'b0;
				si_o = ~si_o;
				#400 sck_o = 1'b1;
				#400 sck_o = 1'b0;
				hold_n_o = 1'b1;
				#400;
			end
			sck_o = 1'b0;
			si_o = tx[i];
			#400 sck_o = 1'b1;
			rx[i] = so_i;
			#400;
		end
	endtask
	// released data line shows the inverse, no pull on it
	task stop();
		sck_o = (mode == 3);
		#400 cs_n_o = 1'b1;
		si_o = ~si_o;
		#800;
	endtask
endmodule // snand_host

// *** verification/serial_nand_spi_addressing_tb.sv ***
/* self-checking bench of the serial nand front end.
   assumes the host model drives the link and the bench the fifo side. */
`timescale 1ns/1ns
module serial_nand_spi_addressing_tb;
	import snand_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ecc_en_i = 1'b1;
	logic rd_valid_i = 1'b0;
	logic [7:0] rd_data_i = 8'h00;
	logic sck_i, cs_n_i, si_i, hold_n_i, so_o, so_oe_n_o, cmd_valid_o, wr_valid_o, rd_ready_o;
	logic held_o;
	logic [7:0] wr_data_o, rx;
	logic [7:0] d[5];
	logic [7:0] ops[3] = '{8'hD8, 8'h13, 8'h10};
	logic [11:0] cols[5] = '{12'h7FF, 12'h83F, 12'h840, 12'h87F, 12'h880};
	cmd_t cmd_o, seen;
	logic [7:0] wr_q[$];
	logic [31:0] seed = 32'h55EE;
	int fails = 0;
	int check_count = 0;
	wire so_w = so_oe_n_o ? 1'bz : so_o;
	always #50 core_clk_i = ~core_clk_i;
	serial_nand_spi_addressing #(.FIFO_DEPTH(4)) serial_nand_spi_addressing_i (.core_clk_i,
		.rst_n_i, .sck_i, .cs_n_i, .si_i, .hold_n_i, .so_o, .so_oe_n_o, .ecc_en_i, .cmd_o,
		.cmd_valid_o, .wr_data_o, .wr_valid_o, .rd_data_i, .rd_valid_i, .rd_ready_o, .held_o);
	snand_host snand_host_i (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .hold_n_o(hold_n_i),
		.so_i(so_w));
	always @(posedge core_clk_i) begin
		if (cmd_valid_o) seen <= cmd_o;
		if (wr_valid_o) wr_q.push_back(wr_data_o);
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// {range error, spare area}: page ends at 2112 or 2176
	function logic [1:0] exp_col(input logic [11:0] c, input logic e);
		return {c >= (e ? 12'h840 : 12'h880), c >= 12'h800};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task give_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#1_000_000;
		fails++;
		give_verdict();
	end
	initial begin
		logic [15:0] row;
		logic [11:0] col;
		repeat (2) @(posedge core_clk_i);
		@(negedge core_clk_i) rst_n_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		for (int k = 0; k < 6; k++) begin
			row = {k == 0 ? 10'h000 : k == 1 ? 10'h3FF : 10'(rnd()), 6'(rnd())};
			seen = '0;
			snand_host_i.start(k[0] ? 3 : 0);
			snand_host_i.xfer(ops[k % 3], 9, rx);
			snand_host_i.xfer(8'(rnd()), 9, rx);
			snand_host_i.xfer(row[15:8], 9, rx);
			snand_host_i.xfer(row[7:0], 9, rx);
			snand_host_i.stop();
			chk(seen.opcode, ops[k % 3]);
			chk({seen.has_row, seen.has_col, seen.column_addr}, 14'h2000);
			chk({seen.block, seen.page}, row);
			chk(seen.block_guaranteed, row[15:6] == 10'h000);
		end
		// unknown opcode: the frame is ignored and no command comes out
		seen = '0;
		snand_host_i.start(0);
		snand_host_i.xfer(8'h9F, 9, rx);
		snand_host_i.xfer(row[15:8], 9, rx);
		snand_host_i.xfer(row[7:0], 9, rx);
		snand_host_i.xfer(8'(rnd()), 9, rx);
		snand_host_i.stop();
		chk({seen.opcode, seen.has_row, seen.has_col}, 10'h000);
		$display("row commands done");
		for (int k = 0; k < 6; k++) begin
			@(negedge core_clk_i);
			col = k < 5 ? cols[k] : 12'(rnd());
			ecc_en_i = k[0];
			d[0] = 8'(rnd());
			d[1] = 8'(rnd());
			wr_q.delete();
			snand_host_i.start(0);
			snand_host_i.xfer(8'h02, 9, rx);
			snand_host_i.xfer({4'(rnd()), col[11:8]}, 9, rx);
			snand_host_i.xfer(col[7:0], 9, rx);
			snand_host_i.xfer(d[0], 3, rx);
			snand_host_i.xfer(d[1], 9, rx);
			snand_host_i.stop();
			chk({seen.has_col, seen.has_row, seen.column_addr}, {2'b10, col});
			chk({seen.col_range_err, seen.col_in_spare}, exp_col(col, k[0]));
			chk(wr_q.size(), 2);
			chk({wr_q[0], wr_q[1]}, {d[0], d[1]});
		end
		$display("program loads with hold done");
		for (int j = 0; j < 5; j++) begin
			@(negedge core_clk_i);
			d[j] = j == 4 ? 8'hFF : 8'(rnd());
			chk(rd_ready_o, j < 4);
			rd_valid_i = 1'b1;
			rd_data_i = j == 4 ? 8'(rnd()) : d[j];
		end
		@(negedge core_clk_i) rd_valid_i = 1'b0;
		snand_host_i.start(3);
		snand_host_i.xfer(8'h03, 9, rx);
		snand_host_i.xfer(8'(rnd()), 9, rx);
		snand_host_i.xfer(8'(rnd()), 9, rx);
		snand_host_i.xfer(8'(rnd()), 9, rx);
		for (int j = 0; j < 5; j++) begin
			snand_host_i.xfer(8'(rnd()), 9, rx);
			chk(rx, d[j]);
		end
		snand_host_i.stop();
		$display("buffer read done");
		give_verdict();
	end
endmodule // serial_nand_spi_addressing_tb
